// [design/pdmmic_buf.sv]
module pdmmic_buf
    import pdmmic_pkg::*;
#(
    parameter int WIDTH = 2,
    parameter int DEPTH = 2
)
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic [$clog2(DEPTH):0] level
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // refuse shapes that the wrapping pointers cannot serve
    if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_shape
        $error("pdmmic_buf: WIDTH >= 1 and DEPTH a power of two >= 2 required");
    end

    logic [WIDTH-1:0]       mem [DEPTH];
    logic [AW-1:0]          wr_ptr_reg;
    logic [AW-1:0]          rd_ptr_reg;
    logic [$clog2(DEPTH):0] count_reg;

    wire do_push = in_valid && in_ready;
    wire do_pop  = out_valid && out_ready;

    assign in_ready  = (count_reg != DEPTH[$clog2(DEPTH):0]);
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_ptr_reg];
    assign level     = count_reg;

    // storage is not reset; a slot is only read after it was written
    always_ff @(posedge pclk)
    begin
        if (do_push)
            mem[wr_ptr_reg] <= in_data;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (do_push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (do_pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (do_push && !do_pop)
                count_reg <= count_reg + 1'b1;
            else if (do_pop && !do_push)
                count_reg <= count_reg - 1'b1;
        end
    end

endmodule : pdmmic_buf

// [design/pdmmic_pkg.sv]
package pdmmic_pkg;

    // ------------------------------------------------------------------
    // register map (word index, byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [9:0] PDMMIC_CTRL_IDX   = 10'h0F1;
    localparam logic [9:0] PDMMIC_STATUS_IDX = 10'h0F2;
    localparam logic [7:0] PDMMIC_CTRL_RST   = 8'h00;
    localparam logic [7:0] PDMMIC_CTRL_MASK  = 8'hC7;

    // ------------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------------
    localparam int PDMMIC_RIGHT_ON_BIT = 7;
    localparam int PDMMIC_LEFT_ON_BIT  = 6;
    localparam int PDMMIC_RATE_BIT     = 2;
    localparam int PDMMIC_PHASE_BIT    = 1;
    localparam int PDMMIC_MAP_BIT      = 0;

    // ------------------------------------------------------------------
    // status fields
    // ------------------------------------------------------------------
    localparam int PDMMIC_ST_RUN_BIT   = 0;
    localparam int PDMMIC_ST_AVAIL_BIT = 1;
    localparam int PDMMIC_ST_OVF_BIT   = 2;

    // ------------------------------------------------------------------
    // clock divide ratios
    // ------------------------------------------------------------------
    localparam logic [3:0] PDMMIC_DIV_FAST = 4'h4;
    localparam logic [3:0] PDMMIC_DIV_SLOW = 4'h8;

    typedef enum logic [1:0] {
        PDMMIC_ST_IDLE = 2'b01,
        PDMMIC_ST_RUN  = 2'b10
    } pdmmic_state_t;

endpackage : pdmmic_pkg

// [design/pdmmic_port.sv]
module pdmmic_port
    import pdmmic_pkg::*;
#(
    parameter int BUF_DEPTH = 2
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // microphone pins
    output logic             pdm_clk_out,
    input  wire logic        pdm_data_in,
    // sample stream: bit 0 left, bit 1 right
    output logic             sample_valid,
    input  wire logic        sample_ready,
    output logic [1:0]       sample_data,
    output logic [1:0]       sample_chan_on
);

    // the buffer pointers wrap by overflow, so only powers of two work
    if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("pdmmic_port: BUF_DEPTH must be a power of two >= 2");
    end

    // ------------------------------------------------------------------
    // register bus decode
    // ------------------------------------------------------------------
    logic [7:0]    ctrl_reg;
    logic          ovf_reg;
    logic [31:0]   prdata_reg;
    logic          pslverr_reg;
    pdmmic_state_t state_reg;
    pdmmic_state_t state_next;

    wire [9:0] word_idx    = paddr[11:2];
    wire       addr_align  = (paddr[1:0] == 2'b00);
    wire       hit_ctrl    = addr_align && (word_idx == PDMMIC_CTRL_IDX);
    wire       hit_status  = addr_align && (word_idx == PDMMIC_STATUS_IDX);
    wire       hit_any     = hit_ctrl || hit_status;
    wire       setup_phase = psel && !penable;
    wire       access_done = psel && penable;
    wire       wr_ctrl     = access_done && pwrite && hit_ctrl && pstrb[0];
    wire       wr_status   = access_done && pwrite && hit_status && pstrb[0];

    // zero wait states: read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg && access_done;

    // ------------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------------
    wire right_chan_on     = ctrl_reg[PDMMIC_RIGHT_ON_BIT];
    wire left_chan_on      = ctrl_reg[PDMMIC_LEFT_ON_BIT];
    wire clk_rate_sel      = ctrl_reg[PDMMIC_RATE_BIT];
    wire capture_phase_sel = ctrl_reg[PDMMIC_PHASE_BIT];
    wire edge_map_sel      = ctrl_reg[PDMMIC_MAP_BIT];
    wire any_chan_on       = right_chan_on || left_chan_on;

    logic [$clog2(BUF_DEPTH):0] buf_level;
    logic                       push_valid;
    logic                       push_ready;

    logic [7:0] status_val;

    // fields are placed by name so the status layout lives in the package only
    always_comb
    begin
        status_val                      = 8'h00;
        status_val[PDMMIC_ST_RUN_BIT]   = (state_reg == PDMMIC_ST_RUN);
        status_val[PDMMIC_ST_AVAIL_BIT] = (buf_level != '0);
        status_val[PDMMIC_ST_OVF_BIT]   = ovf_reg;
    end

    wire [7:0] rd_sel = hit_ctrl ? ctrl_reg : (hit_status ? status_val : 8'h00);

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg    <= PDMMIC_CTRL_RST;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= pwdata[7:0] & PDMMIC_CTRL_MASK;
            if (setup_phase)
            begin
                prdata_reg  <= {24'h00_0000, rd_sel};
                pslverr_reg <= !hit_any;
            end
        end
    end

    // a word lost to a full buffer is flagged; a new loss beats the clear
    wire ovf_set   = push_valid && !push_ready;
    wire ovf_clear = wr_status && pwdata[PDMMIC_ST_OVF_BIT];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ovf_reg <= 1'b0;
        else if (ovf_set)
            ovf_reg <= 1'b1;
        else if (ovf_clear)
            ovf_reg <= 1'b0;
    end

    // ------------------------------------------------------------------
    // microphone clock generator
    // ------------------------------------------------------------------
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic       clk_reg;
    logic       clk_next;

    wire [3:0] div_fast = PDMMIC_DIV_FAST;
    wire [3:0] div_slow = PDMMIC_DIV_SLOW;
    wire [3:0] div_sel  = clk_rate_sel ? div_slow : div_fast;
    wire [2:0] limit    = 3'(div_sel - 4'h1);
    wire [2:0] half     = 3'(div_sel >> 1);
    wire [2:0] quarter  = 3'(div_sel >> 2);
    wire [2:0] cnt_wrap = (cnt_reg >= limit) ? 3'h0 : 3'(cnt_reg + 3'h1);

    always_comb
    begin
        state_next = state_reg;
        cnt_next   = 3'h0;
        clk_next   = 1'b0;
        case (state_reg)
            PDMMIC_ST_IDLE:
            begin
                // start when a channel is on
                if (any_chan_on)
                begin
                    state_next = PDMMIC_ST_RUN;
                    clk_next   = 1'b1;
                end
            end
            PDMMIC_ST_RUN:
            begin
                if (!any_chan_on)
                    state_next = PDMMIC_ST_IDLE;
                else
                begin
                    cnt_next = cnt_wrap;
                    clk_next = (cnt_wrap < half);
                end
            end
            default:
            begin
                state_next = PDMMIC_ST_IDLE;
            end
        endcase
    end

    // stopping mid-period may shorten the last clock pulse; mics tolerate this
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= PDMMIC_ST_IDLE;
            cnt_reg   <= 3'h0;
            clk_reg   <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            clk_reg   <= clk_next;
        end
    end

    assign pdm_clk_out = clk_reg;

    // ------------------------------------------------------------------
    // data capture
    // ------------------------------------------------------------------
    wire running = (state_reg == PDMMIC_ST_RUN);

    wire rise_tap_edge = (cnt_reg == 3'h0);
    wire fall_tap_edge = (cnt_reg == half);
    wire rise_tap_mid  = (cnt_reg == quarter);
    wire fall_tap_mid  = (cnt_reg == 3'(half + quarter));

    // each slot holds one microphone's bit
    wire rise_tap = running && (capture_phase_sel ? rise_tap_mid : rise_tap_edge);
    wire fall_tap = running && (capture_phase_sel ? fall_tap_mid : fall_tap_edge);

    logic rise_bit_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rise_bit_reg <= 1'b0;
        else if (rise_tap)
            rise_bit_reg <= pdm_data_in;
    end

    // rising is left, falling is right unless edge_map_sel swaps them
    wire [1:0] map_norm = {pdm_data_in, rise_bit_reg};
    wire [1:0] map_swap = {rise_bit_reg, pdm_data_in};
    wire [1:0] pair     = edge_map_sel ? map_swap : map_norm;

    wire right_bit = pair[1] && right_chan_on;
    wire left_bit  = pair[0] && left_chan_on;

    assign push_valid = fall_tap;

    // ------------------------------------------------------------------
    // output buffer
    // ------------------------------------------------------------------
    logic [1:0] buf_out_data;

    pdmmic_buf #(
        .WIDTH (2),
        .DEPTH (BUF_DEPTH)
    ) pdmmic_buf_inst (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   ({right_bit, left_bit}),
        .out_valid (sample_valid),
        .out_ready (sample_ready),
        .out_data  (buf_out_data),
        .level     (buf_level)
    );

    assign sample_data    = buf_out_data;
    assign sample_chan_on = {right_chan_on, left_chan_on};

endmodule : pdmmic_port

// [test/pdmmic_mic_model.sv]
module pdmmic_mic_model
(
    input  wire logic pclk,
    input  wire logic pdm_clk,
    input  wire logic rise_bit,
    input  wire logic fall_bit,
    input  wire logic late,
    output logic      pdm_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // two microphones on one line
    // ------------------------------------------------------------
    logic       clk_d = 1'b0;
    logic       junk  = 1'b0;
    logic [3:0] quiet = 4'hF;
    logic       slot;
    always @(posedge pclk)
    begin
        clk_d <= pdm_clk;
        junk  <= ~junk;
        quiet <= (pdm_clk != clk_d) ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
    end
    assign slot = pdm_clk ? rise_bit : fall_bit;
    // a late mic settles one cycle after each clock edge; a stopped clock leaves the line floating
    assign pdm_data = (quiet > 4'h9 && pdm_clk == clk_d) ? junk
                    : ((late && pdm_clk != clk_d) ? ~slot : slot);
endmodule : pdmmic_mic_model

// [test/pdmmic_port_properties.sv]
module pdmmic_port_props
    import pdmmic_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pslverr,
    input wire logic        pdm_clk_out,
    input wire logic        sample_valid,
    input wire logic        sample_ready,
    input wire logic [1:0]  sample_data,
    input wire logic [1:0]  sample_chan_on
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // port checks
    // ------------------------------------------------------------
    logic [11:0] ctrl_a;
    logic [11:0] stat_a;
    logic [1:0]  pw_chan;
    logic        ctl_wr;
    logic        off;
    assign ctrl_a  = {PDMMIC_CTRL_IDX, 2'b00};
    assign stat_a  = {PDMMIC_STATUS_IDX, 2'b00};
    assign pw_chan = pwdata[7:6];
    assign ctl_wr  = psel && penable && pwrite && pstrb[0] && paddr == ctrl_a;
    assign off     = sample_chan_on == 2'b00;
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_chan_mirror: assert property (ctl_wr |=> sample_chan_on == $past(pw_chan))
        else $error("channel enables do not follow the write");
    a_reset_zero: assert property ($rose(presetn) |-> off && !pdm_clk_out)
        else $error("port not idle after reset");
    a_idle_low: assert property (off |=> !pdm_clk_out)
        else $error("mic clock runs with both channels off");
    a_period_min: assert property ($rose(pdm_clk_out) |=> (!$rose(pdm_clk_out)) [*3])
        else $error("mic clock period under four cycles");
    a_period_max: assert property ($rose(pdm_clk_out) |-> ##[1:8] ($rose(pdm_clk_out) || off))
        else $error("mic clock period over eight cycles");
    a_high_min: assert property ($fell(pdm_clk_out) |-> $past(pdm_clk_out, 2) || $past(off))
        else $error("mic clock high phase too short");
    a_hold_stall: assert property (sample_valid && !sample_ready |=> sample_valid && $stable(sample_data))
        else $error("stalled sample changed");
    a_slverr_map: assert property (pslverr == (psel && penable && paddr != ctrl_a && paddr != stat_a))
        else $error("error response does not match the address");
endmodule : pdmmic_port_props

bind pdmmic_port pdmmic_port_props pdmmic_port_props_inst (.*);

// [test/pdmmic_port_tb.sv]
module pdmmic_port_tb
    import pdmmic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] CTRL_A = {PDMMIC_CTRL_IDX, 2'b00};
    localparam logic [11:0] STAT_A = {PDMMIC_STATUS_IDX, 2'b00};
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        pdm_clk_out;
    logic        pdm_data_in;
    logic        sample_valid;
    logic        sample_ready = 1'b1;
    logic [1:0]  sample_data;
    logic [1:0]  sample_chan_on;
    logic        rise_bit = 1'b1;
    logic        fall_bit = 1'b1;
    logic        late = 1'b0;
    logic [31:0] rd;
    logic        err;
    int          fail_count = 0;
    int          comparisons = 0;
    int          cycles = 0;
    pdmmic_port pdmmic_port_inst (
        .pclk           (pclk),
        .presetn        (presetn),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .pstrb          (4'hF),
        .pready         (pready),
        .prdata         (prdata),
        .pslverr        (pslverr),
        .pdm_clk_out    (pdm_clk_out),
        .pdm_data_in    (pdm_data_in),
        .sample_valid   (sample_valid),
        .sample_ready   (sample_ready),
        .sample_data    (sample_data),
        .sample_chan_on (sample_chan_on)
    );
    pdmmic_mic_model pdmmic_mic_model_inst (.pclk, .pdm_clk(pdm_clk_out), .rise_bit,
        .fall_bit, .late, .pdm_data(pdm_data_in));
    always #12.5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            print_verdict();
        end
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: %s got %h", $time, what, got);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // old words drain first, so the checked word was taken under the new setting
    task automatic get_word(input logic [7:0] c, input logic [1:0] exp);
        apb(1'b1, CTRL_A, {24'h000000, c});
        repeat (40) @(posedge pclk);
        while (sample_valid !== 1'b1)
            @(posedge pclk);
        check({30'h0, sample_data}, {30'h0, exp}, "sample word");
    endtask : get_word
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        apb(1'b1, CTRL_A, 32'h000000C7);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, CTRL_A, 32'h00000000);
        check(rd, 32'h00000000, "control after reset");
        check({31'h0, pdm_clk_out}, 32'h0, "idle clock");
        apb(1'b1, CTRL_A, 32'h000000FF);
        apb(1'b0, CTRL_A, 32'h00000000);
        check(rd, 32'h000000C7, "reserved bits");
        apb(1'b1, CTRL_A, 32'h00000000);
        apb(1'b0, 12'h004, 32'h00000000);
        check({31'h0, err}, 32'h1, "unmapped error");
    endtask : t_reset
    task automatic t_rate();
        int   rises;
        logic prev;
        for (int r = 0; r < 2; r++)
        begin
            apb(1'b1, CTRL_A, (r == 1) ? 32'h000000C4 : 32'h000000C0);
            repeat (8) @(posedge pclk);
            rises = 0;
            prev  = pdm_clk_out;
            repeat (32)
            begin
                @(posedge pclk);
                rises += (pdm_clk_out && !prev) ? 1 : 0;
                prev  = pdm_clk_out;
            end
            check(rises, 32 / ((r == 1) ? PDMMIC_DIV_SLOW : PDMMIC_DIV_FAST), "rate");
            apb(1'b1, CTRL_A, 32'h00000000);
            repeat (2) @(posedge pclk);
            check({31'h0, pdm_clk_out}, 32'h0, "clock stopped");
        end
    endtask : t_rate
    task automatic t_chan();
        get_word(8'h40, 2'b01);
        get_word(8'h80, 2'b10);
        get_word(8'hC0, 2'b11);
    endtask : t_chan
    // a late mic is read wrongly at the edge and rightly mid-half
    task automatic t_map_phase();
        logic [1:0] e;
        fall_bit <= 1'b0;
        late     <= 1'b1;
        for (int p = 0; p < 2; p++)
            for (int m = 0; m < 2; m++)
            begin
                e = (p == 1) ? 2'b01 : 2'b10;
                if (m == 1)
                    e = {e[0], e[1]};
                get_word({6'h30, p[0], m[0]}, e);
            end
        get_word(8'hC4, 2'b10);
        get_word(8'hC6, 2'b01);
        late <= 1'b0;
    endtask : t_map_phase
    task automatic t_overflow();
        sample_ready <= 1'b0;
        apb(1'b1, CTRL_A, 32'h000000C0);
        repeat (40) @(posedge pclk);
        apb(1'b0, STAT_A, 32'h00000000);
        check({29'h0, rd[2:0]}, 32'h7, "full status");
        apb(1'b1, CTRL_A, 32'h00000000);
        sample_ready <= 1'b1;
        repeat (4) @(posedge pclk);
        check({31'h0, sample_valid}, 32'h0, "drained");
        apb(1'b1, STAT_A, 32'h00000004);
        apb(1'b0, STAT_A, 32'h00000000);
        check({29'h0, rd[2:0]}, 32'h0, "status cleared");
    endtask : t_overflow
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_rate();
        t_chan();
        t_map_phase();
        t_overflow();
        print_verdict();
    end
endmodule : pdmmic_port_tb
